// ===== design/acs_pkg.sv
// Shared constants and types of the channel sequencer.
// Notes on behaviour
// [RULE_01] Single-ended input type routes the input indexed by the low three channel-pick bits, top bit ignored.
// [RULE_02] Differential type converts an even pick minus the next odd input, an odd pick minus the even one below.
// [RULE_03] The four-input variant decodes only the two lowest channel-pick bits.
// [RULE_04] Format bit 1 gives straight binary, 0 gives two's complement, for either input type.
// [RULE_05] Both power-select bits at 1 keep the converter fully powered whatever the other inputs do.
// [RULE_06] Upper power-select bit 0 powers down after each conversion once the control word is updated.
// [RULE_07] In auto-shutdown the host waits one microsecond of wake-up before trusting a result.
// [RULE_08] Sequencer bits 0,0 make each conversion use the channel-pick of the previous control write.
// [RULE_09] Cycle bit 0 with list-select 1 makes the next transfer load the channel list instead.
// [RULE_10] Once loaded, the listed channels, adjacent or not, are converted one per frame, repeatedly.
// [RULE_11] Cycle 1 with list-select 0 updates the other control bits without disturbing a running sequence.
// [RULE_12] Both sequencer bits at 1 convert channels 0 up to channel-pick, repeating without further writes.
// [RULE_13] Control word: write-enable 12, cycle 11, pick 10:7, power 6:5, list 4, drive 3, span 2, format 1, type 0.
// [RULE_14] List mode steps upward from the lowest listed channel until a write other than cycle 1, list 0.
// [RULE_15] An all-zero channel list converts the highest channel of the variant.
// [RULE_16] Power-select upper 1, lower 0 behaves exactly as full-power operation.
package acs_pkg;
	// Control word layout
	localparam int CW_WE = 12;
	localparam int CW_CYC = 11;
	localparam int CW_PICK_HI = 10;
	localparam int CW_PICK_LO = 7;
	localparam int CW_PWR_HI = 6;
	localparam int CW_PWR_LO = 5;
	localparam int CW_LIST = 4;
	localparam int CW_DRIVE = 3;
	localparam int CW_SPAN = 2;
	localparam int CW_FMT = 1;
	localparam int CW_TYPE = 0;
	localparam int CW_W = 13;
	// Normal power, straight binary, single-ended
	localparam logic [CW_W-1:0] CTRL_RST = 13'h0063;
	// Frame bit counts and the format flip mask
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] CW_LAST_BIT = 5'h0C;
	localparam logic [11:0] FMT_FLIP = 12'h800;
	// Register map, byte addresses
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_LIST = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
	localparam logic [ADDR_W-1:0] REG_RAW = 4'hC;
	localparam logic [11:0] RAW_RST = 12'h000;
	// Status fields
	localparam int STS_CHAN = 0;
	localparam int STS_MODE = 4;
	localparam int STS_EXPECT = 6;
	localparam int STS_PDN = 7;
	localparam int STS_AWAKE = 8;
	localparam int STS_FRAME = 9;
	// Wake-up timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int WAKE_NS = 1000;
	localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_W = 8;
	typedef enum logic [1:0] {SEQ_DIRECT, SEQ_LIST, SEQ_COUNT} acs_seq_e;
endpackage

// ===== design/acs_mux_decode.sv
// Input multiplexer decode and the interface that carries it.
`timescale 1ns/10ps
interface acs_mux_if;
	logic [3:0] chan;
	logic inputType;
	logic [2:0] posSel;
	logic [2:0] negSel;
	logic diff;
	modport req (output chan, inputType, input posSel, negSel, diff);
	modport dec (input chan, inputType, output posSel, negSel, diff);
endinterface

module acs_mux_decode #(
	parameter int NUM_CH = 8
) (
	// Channel and selection
	acs_mux_if.dec mux
);
	// Four-input part keeps two bits, eight-input part three
	localparam logic [2:0] SEL_MASK = 3'(NUM_CH - 1);

	always_comb begin
		mux.posSel = mux.chan[2:0] & SEL_MASK; // see [RULE_01] see [RULE_03]
		if (mux.inputType) begin
			mux.negSel = 3'h0;
			mux.diff = 1'b0;
		end else begin
			// Partner of a pair is the index with bit 0 flipped
			mux.negSel = (mux.chan[2:0] ^ 3'h1) & SEL_MASK; // see [RULE_02]
			mux.diff = 1'b1;
		end
	end
endmodule

// ===== design/acs_sequencer.sv
// Channel sequencer top: serial frames, control word, bus slave.
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
module acs_sequencer #(
	parameter int NUM_CH = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [acs_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Serial link pins
	input wire logic sclk,
	input wire logic frame_select_n,
	input wire logic serialIn,
	output logic serialOut,
	output logic serialOutEn,
	output logic serialOutWeak,
	// Analogue front end control
	output logic [2:0] muxPosSel,
	output logic [2:0] muxNegSel,
	output logic muxDiff,
	output logic spanSel,
	output logic powerDown
);
	import acs_pkg::*;

	localparam logic [2:0] SEL_MASK = 3'(NUM_CH - 1);
	localparam logic [3:0] TOP_CH = 4'(NUM_CH - 1);

	function automatic logic [11:0] fmtCode(input logic [11:0] raw,
			input logic straight);
		fmtCode = straight ? raw : (raw ^ FMT_FLIP); // see [RULE_04]
	endfunction

	// Each list bit names input (position mod channel count)
	function automatic logic [7:0] chanMask(input logic [15:0] w);
		logic [7:0] m;
		m = 8'h00;
		for (int b = 0; b < 16; b++) begin
			if (w[15 - b]) begin
				m[b % NUM_CH] = 1'b1;
			end
		end
		chanMask = m;
	endfunction

	// Next listed channel above cur, wrapping; empty list gives top
	function automatic logic [3:0] nextListed(input logic [7:0] m,
			input logic [3:0] cur);
		logic [3:0] r;
		int c;
		r = TOP_CH; // see [RULE_15]
		for (int i = NUM_CH; i >= 1; i--) begin
			c = (int'(cur) + i) % NUM_CH;
			if (m[c]) begin
				r = 4'(c); // see [RULE_10] see [RULE_14]
			end
		end
		nextListed = r;
	endfunction

	// Pin synchronisers
	logic sclkS1_q, sclkS2_q, sclkS3_q;
	logic csnS1_q, csnS2_q, csnS3_q;
	logic dinS1_q, dinS2_q;
	logic sclkFall, csnFall, csnRise;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclkS1_q <= 1'b1;
			sclkS2_q <= 1'b1;
			sclkS3_q <= 1'b1;
			csnS1_q <= 1'b1;
			csnS2_q <= 1'b1;
			csnS3_q <= 1'b1;
			dinS1_q <= 1'b0;
			dinS2_q <= 1'b0;
		end else begin
			sclkS1_q <= sclk;
			sclkS2_q <= sclkS1_q;
			sclkS3_q <= sclkS2_q;
			csnS1_q <= frame_select_n;
			csnS2_q <= csnS1_q;
			csnS3_q <= csnS2_q;
			dinS1_q <= serialIn;
			dinS2_q <= dinS1_q;
		end
	end

	assign sclkFall = sclkS3_q & ~sclkS2_q;
	assign csnFall = csnS3_q & ~csnS2_q;
	assign csnRise = ~csnS3_q & csnS2_q;

	// Frame and sequencer state
	logic frameActive_q, frameActive_d;
	logic [4:0] bitCnt_q, bitCnt_d;
	logic [15:0] rxShift_q, rxShift_d;
	logic [CW_W-1:0] ctrlRx_q, ctrlRx_d;
	logic ctrlSeen_q, ctrlSeen_d;
	logic [15:0] txShift_q, txShift_d;
	logic serialOut_q, serialOut_d;
	logic serialOutEn_q, serialOutEn_d;
	logic serialOutWeak_q, serialOutWeak_d;
	logic [CW_W-1:0] ctrl_q, ctrl_d;
	acs_seq_e mode_q, mode_d;
	logic expectList_q, expectList_d;
	logic [15:0] list_q, list_d;
	logic [3:0] curChan_q, curChan_d;
	logic [3:0] lastChan_q, lastChan_d;
	logic powerDown_q, powerDown_d;
	logic [WAKE_W-1:0] wakeCnt_q, wakeCnt_d;
	logic [11:0] raw_q, raw_d;
	logic frameEnd, frameDone, listLoad, ctrlWrite;
	logic [3:0] pick, advChan;
	logic [7:0] listMask;

	assign frameEnd = frameActive_q & csnRise;
	assign frameDone = frameEnd & (bitCnt_q == FRAME_BITS);
	assign listLoad = frameDone & expectList_q;
	assign ctrlWrite = frameEnd & ~listLoad & ctrlSeen_q & ctrlRx_q[CW_WE];
	assign pick = ctrlRx_q[CW_PICK_HI:CW_PICK_LO]; // see [RULE_13]
	assign listMask = chanMask(list_q);

	always_comb begin
		// Unused enum code keeps the channel instead of a latch
		advChan = curChan_q;
		unique case (mode_q)
			SEQ_DIRECT: advChan = curChan_q; // see [RULE_08]
			SEQ_LIST: advChan = nextListed(listMask, curChan_q);
			SEQ_COUNT: begin
				// see [RULE_12]
				advChan = (curChan_q >= lastChan_q) ? 4'h0 : curChan_q + 4'h1;
			end
		endcase
	end

	always_comb begin
		frameActive_d = frameActive_q;
		bitCnt_d = bitCnt_q;
		rxShift_d = rxShift_q;
		ctrlRx_d = ctrlRx_q;
		ctrlSeen_d = ctrlSeen_q;
		txShift_d = txShift_q;
		serialOut_d = serialOut_q;
		serialOutEn_d = serialOutEn_q;
		serialOutWeak_d = serialOutWeak_q;
		ctrl_d = ctrl_q;
		mode_d = mode_q;
		expectList_d = expectList_q;
		list_d = list_q;
		curChan_d = curChan_q;
		lastChan_d = lastChan_q;
		powerDown_d = powerDown_q;
		if (csnFall) begin
			// Sample point: wake up and present the address first
			frameActive_d = 1'b1;
			bitCnt_d = 5'h00;
			ctrlSeen_d = 1'b0;
			powerDown_d = 1'b0;
			txShift_d = {curChan_q, fmtCode(raw_q, ctrl_q[CW_FMT])};
			serialOut_d = curChan_q[3];
			serialOutEn_d = 1'b1;
			serialOutWeak_d = 1'b0;
		end else if (frameEnd) begin
			frameActive_d = 1'b0;
			ctrlSeen_d = 1'b0;
			serialOutEn_d = 1'b0;
			if (listLoad) begin
				list_d = rxShift_q;
				mode_d = SEQ_LIST; // see [RULE_10]
				expectList_d = 1'b0;
				curChan_d = nextListed(chanMask(rxShift_q), TOP_CH);
			end else if (ctrlWrite) begin
				unique case ({ctrlRx_q[CW_CYC], ctrlRx_q[CW_LIST]})
					2'b00: begin
						ctrl_d = ctrlRx_q; // see [RULE_13]
						mode_d = SEQ_DIRECT; // see [RULE_08] see [RULE_14]
						expectList_d = 1'b0;
						curChan_d = pick;
					end
					2'b01: begin
						ctrl_d = ctrlRx_q;
						mode_d = SEQ_DIRECT;
						expectList_d = 1'b1; // see [RULE_09]
						curChan_d = pick;
					end
					2'b10: begin
						// Channel fields kept so the sequence runs on
						ctrl_d = {ctrlRx_q[CW_WE:CW_CYC],
							ctrl_q[CW_PICK_HI:CW_PICK_LO],
							ctrlRx_q[CW_PWR_HI:CW_TYPE]}; // see [RULE_11]
						if (frameDone) begin
							curChan_d = advChan;
						end
					end
					2'b11: begin
						ctrl_d = ctrlRx_q;
						mode_d = SEQ_COUNT; // see [RULE_12]
						expectList_d = 1'b0;
						lastChan_d = {1'b0, pick[2:0] & SEL_MASK};
						curChan_d = 4'h0;
					end
				endcase
			end else if (frameDone) begin
				curChan_d = advChan;
			end
			serialOutWeak_d = ctrl_d[CW_DRIVE];
			if (frameDone && !ctrl_d[CW_PWR_HI]) begin
				powerDown_d = 1'b1; // see [RULE_06]
			end
		end else if (frameActive_q && sclkFall && bitCnt_q < FRAME_BITS) begin
			bitCnt_d = bitCnt_q + 5'h01;
			rxShift_d = {rxShift_q[14:0], dinS2_q};
			txShift_d = {txShift_q[14:0], 1'b0};
			serialOut_d = txShift_q[14];
			if (bitCnt_q == CW_LAST_BIT) begin
				ctrlRx_d = {rxShift_q[11:0], dinS2_q};
				ctrlSeen_d = 1'b1;
			end
			if (bitCnt_q == FRAME_BITS - 5'h01) begin
				serialOutEn_d = 1'b0;
				serialOutWeak_d = ctrl_q[CW_DRIVE];
			end
		end
		// Weak idle drive tracks the next address top bit
		if (!frameActive_d && serialOutWeak_d) begin
			serialOut_d = curChan_d[3];
		end
		if (ctrl_d[CW_PWR_HI]) begin
			powerDown_d = 1'b0; // see [RULE_05] see [RULE_16]
		end
	end

	// Wake-up timer only reports; the host must honour the wait
	always_comb begin
		wakeCnt_d = wakeCnt_q;
		if (powerDown_q) begin
			wakeCnt_d = '0; // see [RULE_07]
		end else if (wakeCnt_q != WAKE_W'(WAKE_CYC)) begin
			wakeCnt_d = wakeCnt_q + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			frameActive_q <= 1'b0;
			bitCnt_q <= 5'h00;
			rxShift_q <= 16'h0000;
			ctrlRx_q <= '0;
			ctrlSeen_q <= 1'b0;
			txShift_q <= 16'h0000;
			serialOut_q <= 1'b0;
			serialOutEn_q <= 1'b0;
			serialOutWeak_q <= 1'b0;
			ctrl_q <= CTRL_RST;
			mode_q <= SEQ_DIRECT;
			expectList_q <= 1'b0;
			list_q <= 16'h0000;
			curChan_q <= 4'h0;
			lastChan_q <= 4'h0;
			powerDown_q <= 1'b0;
			wakeCnt_q <= '0;
		end else begin
			frameActive_q <= frameActive_d;
			bitCnt_q <= bitCnt_d;
			rxShift_q <= rxShift_d;
			ctrlRx_q <= ctrlRx_d;
			ctrlSeen_q <= ctrlSeen_d;
			txShift_q <= txShift_d;
			serialOut_q <= serialOut_d;
			serialOutEn_q <= serialOutEn_d;
			serialOutWeak_q <= serialOutWeak_d;
			ctrl_q <= ctrl_d;
			mode_q <= mode_d;
			expectList_q <= expectList_d;
			list_q <= list_d;
			curChan_q <= curChan_d;
			lastChan_q <= lastChan_d;
			powerDown_q <= powerDown_d;
			wakeCnt_q <= wakeCnt_d;
		end
	end

	// Multiplexer selection, registered so the pins are glitch free
	acs_mux_if mux ();
	logic [2:0] muxPos_q, muxNeg_q;
	logic muxDiff_q, spanSel_q;

	assign mux.chan = curChan_q;
	assign mux.inputType = ctrl_q[CW_TYPE];

	acs_mux_decode #(
		.NUM_CH(NUM_CH)
	) u_decode (
		.mux(mux)
	);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			muxPos_q <= 3'h0;
			muxNeg_q <= 3'h0;
			muxDiff_q <= 1'b0;
			spanSel_q <= 1'b0;
		end else begin
			muxPos_q <= mux.posSel;
			muxNeg_q <= mux.negSel;
			muxDiff_q <= mux.diff;
			spanSel_q <= ctrl_q[CW_SPAN];
		end
	end

	// Bus slave: one wait cycle, then the answer
	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;

	always_comb begin
		wait_d = 1'b1;
		rdata_d = rdata_q;
		raw_d = raw_q;
		if ((avs_read || avs_write) && wait_q) begin
			wait_d = 1'b0;
			rdata_d = 32'h00000000;
			if (avs_read) begin
				unique case (avs_address)
					REG_CTRL: rdata_d[CW_W-1:0] = ctrl_q;
					REG_LIST: rdata_d[15:0] = list_q;
					REG_STATUS: begin
						rdata_d[STS_CHAN +: 4] = curChan_q;
						rdata_d[STS_MODE +: 2] = mode_q;
						rdata_d[STS_EXPECT] = expectList_q;
						rdata_d[STS_PDN] = powerDown_q;
						rdata_d[STS_AWAKE] = ctrl_q[CW_PWR_HI] |
							(wakeCnt_q == WAKE_W'(WAKE_CYC));
						rdata_d[STS_FRAME] = frameActive_q;
					end
					REG_RAW: rdata_d[11:0] = raw_q;
					default: rdata_d = 32'h00000000;
				endcase
			end
		end
		// Write lands on the edge that ends the request
		if (avs_write && !wait_q && avs_address == REG_RAW) begin
			if (avs_byteenable[0]) begin
				raw_d[7:0] = avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				raw_d[11:8] = avs_writedata[11:8];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h00000000;
			raw_q <= RAW_RST;
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			raw_q <= raw_d;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign serialOut = serialOut_q;
	assign serialOutEn = serialOutEn_q;
	assign serialOutWeak = serialOutWeak_q;
	assign muxPosSel = muxPos_q;
	assign muxNegSel = muxNeg_q;
	assign muxDiff = muxDiff_q;
	assign spanSel = spanSel_q;
	assign powerDown = powerDown_q;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	chk_se_route: assert property ( // see [RULE_01]
		ctrl_q[CW_TYPE] |=> !muxDiff_q &&
			muxPos_q == ($past(curChan_q[2:0]) & SEL_MASK)
	) else $error("single-ended routing wrong");
	chk_diff_pair: assert property ( // see [RULE_02]
		!ctrl_q[CW_TYPE] |=> muxDiff_q &&
			muxNeg_q == (($past(curChan_q[2:0]) ^ 3'h1) & SEL_MASK)
	) else $error("differential pair wrong");
	chk_variant_mask: assert property ( // see [RULE_03]
		##1 (muxPos_q & ~SEL_MASK) == 3'h0 && (muxNeg_q & ~SEL_MASK) == 3'h0
	) else $error("selection exceeds variant inputs");
	chk_result_fmt: assert property ( // see [RULE_04]
		csnFall |=> txShift_q[11:0] == ($past(ctrl_q[CW_FMT]) ?
			$past(raw_q) : ($past(raw_q) ^ FMT_FLIP))
	) else $error("output coding wrong");
	chk_full_power: assert property ( // see [RULE_05]
		ctrl_q[CW_PWR_HI] |-> !powerDown_q
	) else $error("powered down in normal mode");
	chk_auto_down: assert property ( // see [RULE_06]
		frameDone |=> ctrl_q[CW_PWR_HI] || powerDown_q
	) else $error("no shutdown after conversion");
	chk_direct_hold: assert property ( // see [RULE_08]
		frameEnd && mode_q == SEQ_DIRECT && !ctrlWrite && !listLoad
			|=> $stable(curChan_q)
	) else $error("direct channel moved");
	chk_list_arm: assert property ( // see [RULE_09]
		ctrlWrite && !ctrlRx_q[CW_CYC] && ctrlRx_q[CW_LIST]
			|=> expectList_q ##1 ctrl_q == $past(ctrl_q)
	) else $error("list load not armed");
	chk_list_step: assert property ( // see [RULE_10]
		frameDone && mode_q == SEQ_LIST && !ctrlWrite
			|=> list_q == 16'h0000 || listMask[curChan_q[2:0]]
	) else $error("unlisted channel chosen");
	chk_keep_seq: assert property ( // see [RULE_11]
		ctrlWrite && ctrlRx_q[CW_CYC] && !ctrlRx_q[CW_LIST]
			|=> $stable(mode_q) && $stable(list_q) && $stable(lastChan_q)
	) else $error("sequence disturbed");
	chk_count_step: assert property ( // see [RULE_12]
		frameDone && mode_q == SEQ_COUNT && !ctrlWrite |=> curChan_q ==
			(($past(curChan_q) >= $past(lastChan_q)) ? 4'h0 :
			$past(curChan_q) + 4'h1)
	) else $error("counter step wrong");
	chk_ctrl_layout: assert property ( // see [RULE_13]
		ctrlWrite && !ctrlRx_q[CW_CYC] |=> ctrl_q == $past(ctrlRx_q) &&
			curChan_q == $past(ctrlRx_q[CW_PICK_HI:CW_PICK_LO])
	) else $error("control word not applied");
	chk_list_first: assert property ( // see [RULE_14]
		listLoad && rxShift_q[15] |=> curChan_q == 4'h0 && mode_q == SEQ_LIST
	) else $error("list does not start lowest");
	chk_list_zero: assert property ( // see [RULE_15]
		listLoad && rxShift_q == 16'h0000 |=> curChan_q == TOP_CH
	) else $error("empty list default wrong");

	cov_list_run: cover property (frameDone && mode_q == SEQ_LIST);
	cov_count_wrap: cover property (frameDone && mode_q == SEQ_COUNT &&
		curChan_q == lastChan_q);
	cov_shutdown: cover property (!powerDown_q ##1 powerDown_q);
	cov_list_load: cover property (listLoad);
endmodule

// ===== verif/acs_host_model.sv
// Host side of the serial link: one task per sixteen-clock frame.
`timescale 1ns/10ps
module acs_host_model (
	// Link pins
	output logic sclk,
	output logic frame_select_n,
	output logic serialIn,
	input wire logic serialOut
);
	logic autoOff;
	initial begin
		sclk = 1'b1;
		frame_select_n = 1'b1;
		serialIn = 1'b0;
		autoOff = 1'b0;
	end
	// MSB first; link clock stands high outside frames
	task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
		// Stay clear of the core clock edge the caller returned on
		#2;
		if (autoOff) begin
			#1000;
		end
		frame_select_n = 1'b0;
		serialIn = tx[15];
		for (int i = 15; i >= 0; i--) begin
			#62.5;
			rx[i] = serialOut;
			sclk = 1'b0;
			#62.5;
			sclk = 1'b1;
			// Released data line shows no stale level
			serialIn = (i > 0) ? tx[i-1] : ~tx[0];
		end
		#62.5;
		frame_select_n = 1'b1;
		if (tx[15]) begin
			autoOff = ~tx[9];
		end
		#125;
	endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench of the channel sequencer.
`timescale 1ns/10ps
module tb_top;
	import acs_pkg::*;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, sclk, frame_select_n, serialIn, serialOut;
	logic serialOutEn, serialOutWeak, muxDiff, spanSel, powerDown;
	logic [2:0] muxPosSel, muxNegSel, pos4;
	logic [11:0] raw;
	logic [15:0] rx;
	int mismatches = 0;
	int nTests = 0;

	always #5 core_clk = ~core_clk;

	acs_sequencer #(.NUM_CH(8)) acs_sequencer_inst (.core_clk, .rst_b,
		.avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .sclk,
		.frame_select_n, .serialIn, .serialOut, .serialOutEn,
		.serialOutWeak, .muxPosSel, .muxNegSel, .muxDiff, .spanSel,
		.powerDown);
	// Four-input variant listens to the same frames
	acs_sequencer #(.NUM_CH(4)) acs_sequencer4_inst (.core_clk, .rst_b,
		.avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata(), .avs_waitrequest(), .sclk,
		.frame_select_n, .serialIn, .serialOut(), .serialOutEn(),
		.serialOutWeak(), .muxPosSel(pos4), .muxNegSel(), .muxDiff(),
		.spanSel(), .powerDown());
	acs_host_model acs_host_model_inst (.sclk, .frame_select_n,
		.serialIn, .serialOut);

	task automatic wrap_up();
		if (mismatches == 0 && nTests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		nTests++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= wd;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			mismatches++;
			wrap_up();
		end
	endtask

	// Control frame: {drive, span, format, type} in lo, {cycle, list} in sq
	function automatic logic [15:0] cw(input logic [1:0] sq,
		input logic [3:0] p, input logic [1:0] pw, input logic [3:0] lo);
		return {1'b1, sq[1], p, pw, sq[0], lo, 3'h0};
	endfunction

	function automatic logic [11:0] exp_data(input logic [11:0] r,
		input logic f);
		return f ? r : r ^ FMT_FLIP;
	endfunction

	// Next listed channel upward, wrapping; empty list means the top one
	function automatic logic [2:0] next_ch(input logic [7:0] l,
		input logic [2:0] c);
		logic [2:0] r;
		r = 3'h7;
		for (int k = 8; k >= 1; k--) begin
			if (l[3'(c + k)]) r = 3'(c + k);
		end
		return r;
	endfunction

	task automatic xfer(input logic [15:0] tx);
		acs_host_model_inst.frame(tx, rx);
	endtask

	initial begin
		logic [31:0] rd;
		logic [3:0] p, pp, lo;
		logic [2:0] c;
		logic [7:0] lst;
		logic [15:0] lw, arm;
		logic pf;
		void'($urandom(32'hB73D187C));
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		bus(1'b0, REG_CTRL, 32'h0, rd);
		chk("ctrl reset", {19'h0, CTRL_RST}, rd);
		bus(1'b1, REG_CTRL, 32'h1FFF, rd);
		bus(1'b0, REG_CTRL, 32'h0, rd);
		chk("ctrl ro", {19'h0, CTRL_RST}, rd);
		bus(1'b0, 4'h2, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		pp = 4'h0;
		pf = 1'b1;
		// Direct mode, every power pattern, random picks and types
		for (int i = 0; i < 12; i++) begin
			p = 4'($urandom);
			lo = 4'($urandom);
			raw = 12'($urandom);
			bus(1'b1, REG_RAW, {20'h0, raw}, rd);
			xfer(cw(2'h0, p, 2'(i), lo));
			chk("addr", pp[2:0], rx[14:12]);
			chk("data", exp_data(raw, pf), rx[11:0]);
			chk("pos", p[2:0], muxPosSel);
			chk("neg", lo[0] ? 3'h0 : p[2:0] ^ 3'h1, muxNegSel);
			chk("diff", !lo[0], muxDiff);
			chk("pos4", {1'b0, p[1:0]}, pos4);
			chk("pdn", !i[1], powerDown);
			chk("span", lo[2], spanSel);
			chk("weak", lo[3], serialOutWeak);
			chk("drive off", 32'h0, serialOutEn);
			pp = p;
			pf = lo[1];
		end
		// Counting mode with a format change in mid-sequence
		p = 4'(2 + $urandom % 6);
		xfer(cw(2'h3, p, 2'h3, 4'h3));
		c = 3'h0;
		for (int k = 0; k < 2 * (p + 1); k++) begin
			xfer(k == 2 ? cw(2'h2, 4'h0, 2'h3, 4'h1) : 16'h0);
			chk("count", c, rx[14:12]);
			c = (c == p[2:0]) ? 3'h0 : c + 3'h1;
		end
		chk("fmt kept", exp_data(raw, 1'b0), rx[11:0]);
		// Channel lists: sparse, random, empty
		arm = cw(2'h1, 4'h0, 2'h3, 4'h3);
		for (int j = 0; j < 3; j++) begin
			lst = (j == 0) ? 8'hA5 : ((j == 1) ? 8'($urandom) : 8'h00);
			for (int b = 0; b < 16; b++) lw[15-b] = lst[b%8];
			xfer(arm);
			xfer(lw);
			bus(1'b0, REG_CTRL, 32'h0, rd);
			chk("list frame", {19'h0, arm[15:3]}, rd);
			c = next_ch(lst, 3'h7);
			for (int k = 0; k < 6; k++) begin
				xfer(16'h0);
				chk("list", c, rx[14:12]);
				c = next_ch(lst, c);
			end
		end
		xfer(cw(2'h0, 4'h3, 2'h3, 4'h3));
		xfer(16'h0);
		chk("exit", 3'h3, rx[14:12]);
		wrap_up();
	end

	initial begin
		#500000;
		mismatches++;
		wrap_up();
	end
endmodule
